// ---- src/pio_ctl_pkg.sv ----
// constants, register map and carrier types of the parallel line controller
// assumes a 32-bit word register port with byte addresses

package pio_ctl_pkg;
   localparam int NL = 32;                            // lines per controller
   localparam logic [7:0] A_OWN_EN = 8'h00;
   localparam logic [7:0] A_OWN_DIS = 8'h04;
   localparam logic [7:0] A_OWN_ST = 8'h08;
   localparam logic [7:0] A_OUT_EN = 8'h10;
   localparam logic [7:0] A_OUT_DIS = 8'h14;
   localparam logic [7:0] A_OUT_ST = 8'h18;
   localparam logic [7:0] A_FLT_EN = 8'h20;
   localparam logic [7:0] A_FLT_DIS = 8'h24;
   localparam logic [7:0] A_FLT_ST = 8'h28;
   localparam logic [7:0] A_LVL_SET = 8'h30;
   localparam logic [7:0] A_LVL_CLR = 8'h34;
   localparam logic [7:0] A_LVL_ST = 8'h38;
   localparam logic [7:0] A_PAD_ST = 8'h3c;
   localparam logic [7:0] A_IRQ_EN = 8'h40;
   localparam logic [7:0] A_IRQ_DIS = 8'h44;
   localparam logic [7:0] A_IRQ_MSK = 8'h48;
   localparam logic [7:0] A_IRQ_ST = 8'h4c;
   localparam logic [7:0] A_OD_EN = 8'h50;
   localparam logic [7:0] A_OD_DIS = 8'h54;
   localparam logic [7:0] A_OD_ST = 8'h58;
   localparam logic [7:0] A_PU_DIS = 8'h60;
   localparam logic [7:0] A_PU_EN = 8'h64;
   localparam logic [7:0] A_PU_ST = 8'h68;
   localparam logic [7:0] A_SEL_A = 8'h70;
   localparam logic [7:0] A_SEL_B = 8'h74;
   localparam logic [7:0] A_SEL_ST = 8'h78;
   localparam logic [7:0] A_DW_EN = 8'ha0;
   localparam logic [7:0] A_DW_DIS = 8'ha4;
   localparam logic [7:0] A_DW_ST = 8'ha8;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;  // reset of status words
   localparam logic [31:0] ALL_ONES = 32'hffff_ffff;

   // one register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // all rising edge clocked state of the controller
   typedef struct packed {
      logic [31:0] own;      // line ownership status
      logic [31:0] osr;      // output drive status
      logic [31:0] ifsr;     // glitch filter status
      logic [31:0] odsr;     // output level status
      logic [31:0] imr;      // change irq mask
      logic [31:0] isr;      // change irq status
      logic [31:0] mdsr;     // open drain status
      logic [31:0] pusr;     // pullup status
      logic [31:0] absr;     // peripheral select status
      logic [31:0] owsr;     // direct write status
      logic [31:0] s1;       // pad sync first stage
      logic [31:0] s2;       // pad sync second stage
      logic [31:0] flt;      // glitch filtered level
      logic [31:0] lvl;      // reported pad level
      logic [31:0] rdata;    // read data
      logic [31:0] pad_o;    // pad drive value
      logic [31:0] pad_oe;   // pad drive enable
      logic irq;             // interrupt out
   } st_t;
endpackage : pio_ctl_pkg

// ---- src/pio_ctl.sv ----
// parallel line controller: 32 lines, register port, change interrupt
// assumes mclk at 10 MHz; clk_run is the power manager gate, same domain
//
// Contract
// - pad level register shows real pad level
// - clock off: pad level register holds last
// - filter rejects under half, accepts one and a half cycles
// - filter latency one cycle or none
// - filter enable sets, disable clears status
// - filter affects level and change only
// - filter works only while clock runs
// - irq enable sets, disable clears mask
// - change from two successive clocked samples
// - change detected in every line configuration
// - change sets status; masked status raises irq
// - all line conditions ORed into irq
// - status read clears all status bits; a change in the read cycle stays set
// - irq status resets to zero
// - unimplemented line bits ignore writes, read zero
// - unmultiplexed line ownership always reads one
// - direct write only where write status set
// - select A clears, select B sets
// - ownership enable one gives line to controller
// - ownership reset per product; others zero
// - ownership disable one gives line to peripheral
// - select bit picks peripheral A or B
// - drive pad when output set and owned, unless open drain with level high
// - level set and clear regardless of owner

`timescale 1ns/1ps
`default_nettype none

module pio_ctl
   import pio_ctl_pkg::*;
#(
   parameter logic [31:0] LINE_IMPL = 32'hffff_ffff, // implemented lines
   parameter logic [31:0] LINE_MUX = 32'hffff_ffff,  // lines with peripherals
   parameter logic [31:0] OWN_RST = 32'hffff_ffff    // ownership reset value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_run,
   input wire bus_req_t req,
   output logic [31:0] rdata,
   output logic irq,
   input wire logic [31:0] pad_in,
   output logic [31:0] pad_o,
   output logic [31:0] pad_oe,
   output logic [31:0] pullup_off,
   output logic [31:0] periph_in,
   input wire logic [31:0] pa_o,
   input wire logic [31:0] pa_oe,
   input wire logic [31:0] pb_o,
   input wire logic [31:0] pb_oe
);

   st_t st_ff;           // registered state
   st_t nxt_st;          // next state
   logic [31:0] n1_ff;   // falling edge sync first stage
   logic [31:0] n2_ff;   // falling edge sync second stage
   logic [31:0] n3_ff;   // falling edge sample, half a cycle older than s2
   logic [31:0] wd;      // write data cut to implemented lines
   logic [31:0] own_rd;  // ownership seen by software
   logic [31:0] raw;     // level before the clock gate
   logic [31:0] chg;     // detected changes this cycle
   logic [31:0] drv;     // value offered to the pad
   logic [31:0] en;      // enable offered to the pad

   // falling edge sampler for the half cycle filter
   // the third stage lines up a falling sample half a cycle before s2,
   // so a change just before a falling edge passes with no extra delay
   // while a change just before a rising edge waits one more cycle
   always_ff @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         n1_ff <= RST_ZERO;
         n2_ff <= RST_ZERO;
         n3_ff <= RST_ZERO;
      end else begin
         n1_ff <= pad_in;
         n2_ff <= n1_ff;
         n3_ff <= n2_ff;
      end
   end

   // next state of all rising edge logic
   always_comb begin
      nxt_st = st_ff;
      wd = req.wdata & LINE_IMPL;
      own_rd = (st_ff.own | ~LINE_MUX) & LINE_IMPL;
      // pad synchronizer
      nxt_st.s1 = pad_in;
      nxt_st.s2 = st_ff.s1;
      // filter moves only when both half samples agree
      if (clk_run) begin
         nxt_st.flt = (st_ff.s2 & n3_ff) | (st_ff.flt & (st_ff.s2 | n3_ff));
      end
      // filtered lines take the new filter value, no extra register stage
      raw = (st_ff.ifsr & nxt_st.flt) | (~st_ff.ifsr & st_ff.s2);
      chg = RST_ZERO;
      // level and change only while the clock runs
      if (clk_run) begin
         nxt_st.lvl = raw & LINE_IMPL;
         chg = (raw ^ st_ff.lvl) & LINE_IMPL;
      end
      // status read clears, a new change still lands
      nxt_st.isr = st_ff.isr;
      if (req.rd && req.addr == A_IRQ_ST) begin
         nxt_st.isr = RST_ZERO;
      end
      nxt_st.isr = nxt_st.isr | chg;
      // register writes
      if (req.wr) begin
         unique case (req.addr)
            A_OWN_EN: nxt_st.own = st_ff.own | wd;
            A_OWN_DIS: nxt_st.own = st_ff.own & ~wd;
            A_OUT_EN: nxt_st.osr = st_ff.osr | wd;
            A_OUT_DIS: nxt_st.osr = st_ff.osr & ~wd;
            A_FLT_EN: nxt_st.ifsr = st_ff.ifsr | wd;
            A_FLT_DIS: nxt_st.ifsr = st_ff.ifsr & ~wd;
            A_LVL_SET: nxt_st.odsr = st_ff.odsr | wd;
            A_LVL_CLR: nxt_st.odsr = st_ff.odsr & ~wd;
            A_LVL_ST: nxt_st.odsr = (st_ff.odsr & ~st_ff.owsr) | (wd & st_ff.owsr);
            A_IRQ_EN: nxt_st.imr = st_ff.imr | wd;
            A_IRQ_DIS: nxt_st.imr = st_ff.imr & ~wd;
            A_OD_EN: nxt_st.mdsr = st_ff.mdsr | wd;
            A_OD_DIS: nxt_st.mdsr = st_ff.mdsr & ~wd;
            A_PU_DIS: nxt_st.pusr = st_ff.pusr | wd;
            A_PU_EN: nxt_st.pusr = st_ff.pusr & ~wd;
            A_SEL_A: nxt_st.absr = st_ff.absr & ~wd;
            A_SEL_B: nxt_st.absr = st_ff.absr | wd;
            A_DW_EN: nxt_st.owsr = st_ff.owsr | wd;
            A_DW_DIS: nxt_st.owsr = st_ff.owsr & ~wd;
            default: ;                                     // read-only or unmapped
         endcase
      end
      // read data, one cycle after the strobe
      nxt_st.rdata = RST_ZERO;
      if (req.rd) begin
         unique case (req.addr)
            A_OWN_ST: nxt_st.rdata = own_rd;
            A_OUT_ST: nxt_st.rdata = st_ff.osr;
            A_FLT_ST: nxt_st.rdata = st_ff.ifsr;
            A_LVL_ST: nxt_st.rdata = st_ff.odsr;
            A_PAD_ST: nxt_st.rdata = st_ff.lvl;
            A_IRQ_MSK: nxt_st.rdata = st_ff.imr;
            A_IRQ_ST: nxt_st.rdata = st_ff.isr;
            A_OD_ST: nxt_st.rdata = st_ff.mdsr;
            A_PU_ST: nxt_st.rdata = st_ff.pusr;
            A_SEL_ST: nxt_st.rdata = st_ff.absr;
            A_DW_ST: nxt_st.rdata = st_ff.owsr;
            default: nxt_st.rdata = RST_ZERO;
         endcase
      end
      // ORed interrupt from masked status
      nxt_st.irq = |(nxt_st.isr & st_ff.imr);
      // pad mux: controller when owned, else selected peripheral
      drv = st_ff.odsr;
      en = st_ff.osr & ~(st_ff.mdsr & st_ff.odsr);
      for (int i = 0; i < NL; i++) begin
         if (!own_rd[i]) begin
            drv[i] = st_ff.absr[i] ? pb_o[i] : pa_o[i];
            en[i] = st_ff.absr[i] ? pb_oe[i] : pa_oe[i];
            if (st_ff.mdsr[i] && drv[i]) begin
               en[i] = 1'b0;                               // open drain lets high float
            end
         end
      end
      nxt_st.pad_o = drv & LINE_IMPL;
      nxt_st.pad_oe = en & LINE_IMPL;
   end

   // one register bank for all rising edge state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.own <= OWN_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // peripheral inputs bypass the filter
   assign periph_in = st_ff.s2;
   assign rdata = st_ff.rdata;
   assign irq = st_ff.irq;
   assign pad_o = st_ff.pad_o;
   assign pad_oe = st_ff.pad_oe;
   assign pullup_off = st_ff.pusr;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_isr_read;
      req.rd && req.addr == A_IRQ_ST;
   endsequence

   a_isr_read_clear: assert property (s_isr_read |=> st_ff.isr == $past(chg))
      else $error("status not cleared by read");
   a_change_kept: assert property (s_isr_read ##0 (chg != 0) |=> (st_ff.isr & $past(chg)) == $past(chg))
      else $error("change lost on status read");
   a_irq_or: assert property (##1 irq == |($past(nxt_st.isr) & $past(st_ff.imr)))
      else $error("irq does not match masked status");
   a_level_hold: assert property (!clk_run |=> st_ff.lvl == $past(st_ff.lvl))
      else $error("pad level moved with clock off");
   a_no_change_off: assert property (!clk_run |-> chg == 0)
      else $error("change seen with clock off");
   a_direct_mask: assert property (req.wr && req.addr == A_LVL_ST |=>
      ((st_ff.odsr ^ $past(st_ff.odsr)) & ~$past(st_ff.owsr)) == 0)
      else $error("direct write hit masked bit");
   a_flt_set: assert property (req.wr && req.addr == A_FLT_EN |=>
      (st_ff.ifsr & $past(wd)) == $past(wd))
      else $error("filter enable failed");
   a_mask_clear: assert property (req.wr && req.addr == A_IRQ_DIS |=>
      (st_ff.imr & $past(wd)) == 0)
      else $error("irq disable failed");
   a_own_fixed: assert property (req.rd && req.addr == A_OWN_ST |=>
      (rdata & ~LINE_MUX & LINE_IMPL) == (~LINE_MUX & LINE_IMPL))
      else $error("unmultiplexed ownership not one");
   a_unimpl_zero: assert property (req.rd |=> (rdata & ~LINE_IMPL) == 0)
      else $error("unimplemented bit reads one");
   a_sel_b: assert property (req.wr && req.addr == A_SEL_B |=>
      (st_ff.absr & $past(wd)) == $past(wd))
      else $error("select B did not set");
   // filter state is frozen while the clock gate is off
   a_flt_frozen: assert property (!clk_run |=> st_ff.flt == $past(st_ff.flt))
      else $error("filter moved with clock off");
   // filter output moves only where rising and falling samples agreed
   a_flt_agree: assert property (##1 ((st_ff.flt ^ $past(st_ff.flt)) & ($past(st_ff.s2) ^ $past(n3_ff))) == 0)
      else $error("filter passed a disagreeing sample");
   // an owned line with output status clear is never driven
   a_own_drive: assert property (##1 (pad_oe & $past(own_rd) & ~$past(st_ff.osr)) == 0)
      else $error("owned input line driven");

endmodule : pio_ctl

`default_nettype wire

// ---- test/pad_model.sv ----
// pad model: each line's level from the controller drive and an outside driver
// assumes the outside driver always holds undriven lines at a known level
`timescale 1ns/1ps
`default_nettype none

module pad_model (
   input wire logic [31:0] pad_o,
   input wire logic [31:0] pad_oe,
   input wire logic [31:0] ext,
   output logic [31:0] pad_in
);
   // a driven line shows the drive value, the others the outside level
   assign pad_in = (pad_o & pad_oe) | (ext & ~pad_oe);
endmodule : pad_model

`default_nettype wire

// ---- test/pio_ctl_test.sv ----
// self-checking bench of the parallel line controller
// assumes pad_model is compiled first; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none

module pio_ctl_test;
   import pio_ctl_pkg::*;
   localparam logic [31:0] IMPL = 32'h7fff_ffff; // line 31 absent
   localparam logic [31:0] MUX = 32'hffff_fff0;  // lines 0..3 unmultiplexed
   localparam logic [31:0] ORST = 32'h0000_ff00; // ownership reset pattern
   logic mclk, rst_n, clk_run, irq, rd_d;
   bus_req_t req;
   logic [31:0] rdata, pad_in, pad_o, pad_oe, ext, pa_o, pa_oe, pb_o, pb_oe, pu_off, p_in;
   logic [31:0] seed, x, y, m, d, o, f;
   logic [31:0] exp_q[$], msk_q[$];         // pending read expectations
   int err_count, cmp_count;
   // set, clear and status address of each paired register except the output level
   logic [7:0] s_a[8] = '{A_OUT_EN, A_FLT_EN, A_IRQ_EN, A_OD_EN, A_PU_DIS, A_SEL_B, A_DW_EN, A_OWN_EN};
   logic [7:0] c_a[8] = '{A_OUT_DIS, A_FLT_DIS, A_IRQ_DIS, A_OD_DIS, A_PU_EN, A_SEL_A, A_DW_DIS, A_OWN_DIS};
   logic [7:0] t_a[8] = '{A_OUT_ST, A_FLT_ST, A_IRQ_MSK, A_OD_ST, A_PU_ST, A_SEL_ST, A_DW_ST, A_OWN_ST};

   pio_ctl #(.LINE_IMPL(IMPL), .LINE_MUX(MUX), .OWN_RST(ORST)) uut (.mclk(mclk), .rst_n(rst_n),
      .clk_run(clk_run), .req(req), .rdata(rdata), .irq(irq), .pad_in(pad_in), .pad_o(pad_o),
      .pad_oe(pad_oe), .pullup_off(pu_off), .periph_in(p_in), .pa_o(pa_o), .pa_oe(pa_oe), .pb_o(pb_o),
      .pb_oe(pb_oe));
   pad_model pads (.pad_o(pad_o), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // expected pad word while lines 0..7 are driven from the output level
   function automatic logic [31:0] pe(input logic [31:0] e);
      return ((o & 32'h0000_00ff) | (e & 32'hffff_ff00)) & IMPL;
   endfunction : pe

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk

   // one strobe cycle, then idle so the next request sees a clean edge
   task automatic bus(input logic [7:0] a, input logic [31:0] dt, input logic we);
      @(posedge mclk);
      req <= '{a, dt, we, !we};
      @(posedge mclk);
      req <= '0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk = ALL_ONES);
      exp_q.push_back(e & mk);
      msk_q.push_back(mk);
      bus(a, '0, 1'b0);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // clock of 100 ns period
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end

   // read data watcher: the cycle after a read strobe takes the oldest note
   always @(posedge mclk) begin
      if (rd_d) chk("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
      rd_d <= req.rd;
   end

   // hang guard
   initial begin
      #200_000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      rst_n = 0; clk_run = 1; req = '0; ext = '0; rd_d = 0; seed = 32'h0000_0063;
      pa_o = '0; pa_oe = '0; pb_o = '0; pb_oe = '0; err_count = 0; cmp_count = 0;
      idle(4);
      rst_n <= 1;
      // reset values, reads of write-only and unmapped places
      for (int i = 0; i < 8; i++) rd(t_a[i], (i == 7) ? (ORST | ~MUX) & IMPL : '0);
      rd(A_IRQ_ST, '0);
      rd(8'h0c, '0);
      rd(A_OWN_EN, '0);
      // set, clear and read-only behaviour of every paired register except the output level
      for (int i = 0; i < 8; i++) begin
         f = (i == 7) ? ~MUX : '0;
         x = rnd();
         y = rnd();
         bus(c_a[i], ALL_ONES, 1);
         bus(s_a[i], x, 1);
         rd(t_a[i], (x | f) & IMPL);
         bus(c_a[i], y, 1);
         rd(t_a[i], ((x & ~y) | f) & IMPL);
         if (i == 4) chk("pullup_off", pu_off, (x & ~y) & IMPL);
         bus(t_a[i], ALL_ONES, 1);
         rd(t_a[i], ((x & ~y) | f) & IMPL);
         bus(c_a[i], ALL_ONES, 1);
      end
      // output level by set, clear and masked direct write
      x = rnd(); y = rnd(); m = rnd(); d = rnd();
      bus(A_LVL_SET, x, 1);
      bus(A_LVL_CLR, y, 1);
      bus(A_DW_EN, m, 1);
      bus(A_LVL_ST, d, 1);
      o = ((x & ~y & ~m) | (d & m)) & IMPL;
      rd(A_LVL_ST, o);
      // drive lines 0..7, outside level on the rest
      bus(A_OWN_EN, ALL_ONES, 1);
      bus(A_OUT_EN, 32'h0000_00ff, 1);
      ext <= rnd();
      idle(5);
      chk("pad_oe", pad_oe, 32'h0000_00ff);
      rd(A_PAD_ST, pe(ext));
      chk("periph_in", p_in & IMPL, pe(ext));
      // lines 4 and 5 to peripherals A and B
      pa_o <= rnd(); pa_oe <= rnd(); pb_o <= rnd(); pb_oe <= rnd();
      bus(A_OWN_DIS, 32'h0000_0030, 1);
      bus(A_SEL_B, 32'h0000_0020, 1);
      idle(3);
      m = (pa_oe & 32'h0000_0010) | (pb_oe & 32'h0000_0020);
      chk("pad_oe", pad_oe & 32'h0000_0030, m);
      chk("pad_o", pad_o & m, ((pa_o & 32'h0000_0010) | (pb_o & 32'h0000_0020)) & m);
      bus(A_OWN_EN, ALL_ONES, 1);
      // gated clock freezes the pad level word
      ext <= rnd();
      idle(5);
      x = ext;
      clk_run <= 0;
      ext <= rnd();
      idle(5);
      rd(A_PAD_ST, pe(x));
      clk_run <= 1;
      idle(5);
      rd(A_PAD_ST, pe(ext));
      // change events on a driven line and an input line
      rd(A_IRQ_ST, '0, '0);
      bus(A_IRQ_EN, 32'h0000_0008, 1);
      bus(o[3] ? A_LVL_CLR : A_LVL_SET, 32'h0000_0008, 1);
      ext <= ext ^ 32'h0000_0200;
      idle(6);
      chk("irq", {31'b0, irq}, 32'h0000_0001);
      rd(A_IRQ_ST, 32'h0000_0208);
      rd(A_IRQ_ST, '0);
      idle(2);
      chk("irq", {31'b0, irq}, '0);
      ext <= ext ^ 32'h0000_0200;
      idle(6);
      chk("irq", {31'b0, irq}, '0);
      rd(A_IRQ_ST, 32'h0000_0200);
      // filtered line 10: a short glitch over a rising edge, then a long pulse
      bus(A_FLT_EN, 32'h0000_0400, 1);
      @(posedge mclk);
      #80 ext[10] = ~ext[10];
      #40 ext[10] = ~ext[10];
      idle(6);
      rd(A_IRQ_ST, '0);
      @(posedge mclk);
      #20 ext[10] = ~ext[10];
      #200 ext[10] = ~ext[10];
      idle(6);
      rd(A_IRQ_ST, 32'h0000_0400);
      idle(2);
      tally_and_finish();
   end
endmodule : pio_ctl_test

`default_nettype wire
